// ==== pkg/tcdma_pkg.sv ====
// Constants and types shared by the three-channel transfer controller
// Overview of operation
// RULE1: Three channels: two peripheral movers and one converter result sequencer.
// RULE2: Each peripheral channel moves data in its one configured direction only.
// RULE3: On trigger, request the bus, await acknowledge, move byte or word, release.
// RULE4: After the end-address transfer, current address reloads from start address.
// RULE5: With interrupts enabled, end-address transfer raises an interrupt request.
// RULE6: Single-pass mode clears the channel enable bit after the end-address transfer.
// RULE7: Otherwise current address steps by 1 in byte mode, 2 in word mode.
// RULE8: Peripheral address is Fh joined with the 8-bit peripheral address byte.
// RULE9: Start address is high-nibble register bits 3:0 joined with start low byte.
// RULE10: End address is high-nibble register bits 7:4 joined with end low byte.
// RULE11: Software writes address bytes first and the control byte last.
// RULE12: Control write selects mode, direction, interrupt, size, trigger and enables.
// RULE13: Converter signals each finished conversion with two result bytes ready.
// RULE14: Converter channel takes the bus, writes both result bytes, releases it.
// RULE15: After the highest selected input, input number wraps to 0 and restarts.
// RULE16: With interrupts enabled, converter channel interrupts after highest input.
// RULE17: Otherwise the converter channel starts conversion on the next input.
// RULE18: Converter address register holds the top 7 bits of destination address.
// RULE19: Converter control gives interrupt enable, input count and channel enable.
// RULE20: Software keeps converter single-shot when input count exceeds 000b.
// RULE21: Continuous converter mode only with input count 000b.
// RULE22: Disabled peripheral channel ignores triggers; enabled one serves each.
// RULE23: Word transfers need an even peripheral address byte.
// RULE24: Trigger select codes 000-010 and 100-110 pick sources; 111 reserved.
// RULE25: Simultaneous requests are granted one at a time, peripherals first.
// RULE26: Bus request held until acknowledge, dropped the cycle after completion.
package tcdma_pkg;
   localparam int ADDR_W = 12;
   localparam int BUF_DEPTH = 2;
   // Control byte field positions
   localparam int CTL_EN_BIT = 7;
   localparam int CTL_LOOP_BIT = 6;
   localparam int CTL_DIR_BIT = 5;
   localparam int CTL_IRQ_BIT = 4;
   localparam int CTL_WORD_BIT = 3;
   localparam int CTL_RSS_LSB = 0;
   // High-nibble register field positions
   localparam int HI_START_LSB = 0;
   localparam int HI_END_LSB = 4;
   localparam logic [3:0] PERIPH_PAGE = 4'hf;
   // Codes 011 and 111 select no source
   localparam logic [7:0] TRIG_VALID_MASK = 8'h77;
   localparam logic [11:0] ADDR_STEP_BYTE = 12'h001;
   localparam logic [11:0] ADDR_STEP_WORD = 12'h002;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [2:0] INPUT_FIRST = 3'h0;
   localparam logic [1:0] OWN_P0 = 2'h0;
   localparam logic [1:0] OWN_P1 = 2'h1;
   localparam logic [1:0] OWN_ADC = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_REQ = 3'h1,
      ST_RD = 3'h2,
      ST_LAT = 3'h3,
      ST_WR = 3'h4,
      ST_DONE = 3'h5
   } tcdma_state_e;

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] io;
      logic [7:0] hi;
      logic [7:0] start_lo;
      logic [7:0] end_lo;
   } tcdma_pcfg_s;

   typedef struct packed {
      logic irq_en;
      logic [2:0] in_count;
      logic enable;
   } tcdma_acfg_s;

   typedef struct packed {
      logic [2:0] in_num;
      logic [15:0] data;
   } tcdma_ares_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } tcdma_mem_s;
endpackage

// ==== src/tcdma_buf2.sv ====
// Two-entry valid/ready buffer on the converter result path
`timescale 1ns/1ps
module tcdma_buf2 import tcdma_pkg::*; #(
   parameter int W = 19,
   parameter int D = BUF_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(D);
   logic [D-1:0][W-1:0] mem_q;
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (PW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(D-1)) ? '0 : PW'(p + 1'b1);
   endfunction

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= nxt(wp_q);
         end
         if (pop) begin
            rp_q <= nxt(rp_q);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// ==== src/tcdma_ctrl.sv ====
// Three-channel transfer controller: two peripheral movers, one converter
`timescale 1ns/1ps
module tcdma_ctrl import tcdma_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire tcdma_pcfg_s [1:0] pch_cfg,
   input wire logic [1:0] pch_load,
   input wire logic [1:0][7:0] pch_trig,
   output logic [1:0] pch_enable,
   output logic [1:0][11:0] pch_cur_addr,
   output logic [1:0] pch_irq,
   input wire logic [6:0] adc_addr7,
   input wire tcdma_acfg_s adc_cfg,
   input wire logic adc_load,
   input wire logic adc_done,
   input wire logic [15:0] adc_data,
   output logic adc_ready,
   output logic adc_start,
   output logic [2:0] adc_input_sel,
   output logic adc_irq,
   output logic adc_enable,
   output logic bus_req,
   input wire logic bus_ack,
   output tcdma_mem_s mem_bus,
   input wire logic [7:0] mem_rdata
);
   tcdma_pcfg_s [1:0] cfg_q;
   logic [1:0] en_q;
   logic [1:0] pend_q;
   logic [1:0][11:0] cur_q;
   logic [1:0] pirq_q;
   logic [6:0] abase_q;
   tcdma_acfg_s acfg_q;
   logic [2:0] in_q;
   logic astart_q;
   logic airq_q;
   tcdma_state_e st_q;
   logic [1:0] own_q;
   logic bi_q;
   tcdma_mem_s mem_q;
   logic [1:0] trig_hit;
   logic [1:0] step_pch;
   logic [1:0] hit_end;
   logic step_adc;
   logic buf_vld;
   tcdma_ares_s buf_out;
   tcdma_ares_s buf_in;
   logic own_is_p;
   logic own_word;
   logic own_dir;
   logic [11:0] rf_addr;
   logic [11:0] pr_addr;
   logic [11:0] adc_dst;

   // Pick the trigger line named by the select field; reserved codes never fire
   function automatic logic trig_pick(input logic [7:0] ctl,
                                      input logic [7:0] lines);
      logic [7:0] ok;
      ok = lines & TRIG_VALID_MASK;
      trig_pick = ok[ctl[CTL_RSS_LSB +: 3]]; // [RULE24]
   endfunction

   function automatic logic [11:0] start_of(input tcdma_pcfg_s c);
      start_of = {c.hi[HI_START_LSB +: 4], c.start_lo}; // [RULE9]
   endfunction

   function automatic logic [11:0] end_of(input tcdma_pcfg_s c);
      end_of = {c.hi[HI_END_LSB +: 4], c.end_lo}; // [RULE10]
   endfunction

   assign pch_enable = en_q;
   assign pch_cur_addr = cur_q;
   assign pch_irq = pirq_q;
   assign adc_start = astart_q;
   assign adc_input_sel = in_q;
   assign adc_irq = airq_q;
   assign adc_enable = acfg_q.enable;
   assign mem_bus = mem_q;
   // Request stands from arbitration until the last byte; drops in DONE
   assign bus_req = (st_q == ST_REQ) || (st_q == ST_RD) ||
                    (st_q == ST_LAT) || (st_q == ST_WR); // [RULE26]

   assign own_is_p = (own_q != OWN_ADC);
   assign own_word = cfg_q[own_q[0]].ctl[CTL_WORD_BIT];
   assign own_dir = cfg_q[own_q[0]].ctl[CTL_DIR_BIT];
   assign rf_addr = cur_q[own_q[0]] + {11'h000, bi_q};
   assign pr_addr = {PERIPH_PAGE, cfg_q[own_q[0]].io + {7'h00, bi_q}}; // [RULE8]
   // Two result bytes per input, high byte at the even address
   assign adc_dst = {abase_q, 1'b0, buf_out.in_num, bi_q}; // [RULE18]

   assign buf_in = '{in_num: in_q, data: adc_data};
   assign step_adc = (st_q == ST_DONE) && (own_q == OWN_ADC); // [RULE1]

   for (genvar i = 0; i < 2; i++) begin : g_pch
      assign trig_hit[i] = trig_pick(cfg_q[i].ctl, pch_trig[i]);
      assign step_pch[i] = (st_q == ST_DONE) && (own_q == 2'(i));
      assign hit_end[i] = (cur_q[i] == end_of(cfg_q[i]));
   end

   tcdma_buf2 #(
      .W($bits(tcdma_ares_s)),
      .D(BUF_DEPTH)
   ) u_buf (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(adc_done), // [RULE13]
      .in_ready(adc_ready),
      .in_data(buf_in),
      .out_valid(buf_vld),
      .out_ready(step_adc),
      .out_data(buf_out)
   );

   // Peripheral channel configuration, enable and address stepping
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= '0;
         en_q <= '0;
         cur_q <= '0;
         pirq_q <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            pirq_q[i] <= 1'b0;
            if (pch_load[i]) begin
               cfg_q[i] <= pch_cfg[i]; // [RULE12]
               en_q[i] <= pch_cfg[i].ctl[CTL_EN_BIT];
               cur_q[i] <= start_of(pch_cfg[i]);
            end else if (step_pch[i]) begin
               if (hit_end[i]) begin
                  cur_q[i] <= start_of(cfg_q[i]); // [RULE4]
                  pirq_q[i] <= cfg_q[i].ctl[CTL_IRQ_BIT]; // [RULE5]
                  if (!cfg_q[i].ctl[CTL_LOOP_BIT]) begin
                     en_q[i] <= 1'b0; // [RULE6]
                  end
               end else if (cfg_q[i].ctl[CTL_WORD_BIT]) begin
                  cur_q[i] <= cur_q[i] + ADDR_STEP_WORD; // [RULE7]
               end else begin
                  cur_q[i] <= cur_q[i] + ADDR_STEP_BYTE; // [RULE7]
               end
            end
         end
      end
   end

   // Grant order among pending channels, channel 0 first
   function automatic logic own_sel_ok(input int i);
      own_sel_ok = (i == 0) ? pend_q[0] : (pend_q[1] && !pend_q[0]);
   endfunction

   // Pending triggers; a new trigger beats the grant clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!en_q[i]) begin
               pend_q[i] <= 1'b0; // [RULE22]
            end else if (trig_hit[i]) begin
               pend_q[i] <= 1'b1; // [RULE22]
            end else if (st_q == ST_IDLE && own_sel_ok(i)) begin
               pend_q[i] <= 1'b0;
            end
         end
      end
   end

   // Converter channel: configuration and input sequencing
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         abase_q <= '0;
         acfg_q <= '0;
         in_q <= INPUT_FIRST;
         astart_q <= 1'b0;
         airq_q <= 1'b0;
      end else begin
         astart_q <= 1'b0;
         airq_q <= 1'b0;
         if (adc_load) begin
            abase_q <= adc_addr7; // [RULE18]
            acfg_q <= adc_cfg; // [RULE19]
            in_q <= INPUT_FIRST;
            astart_q <= adc_cfg.enable;
         end else if (step_adc) begin
            if (buf_out.in_num >= acfg_q.in_count) begin
               in_q <= INPUT_FIRST; // [RULE15]
               airq_q <= acfg_q.irq_en; // [RULE16]
            end else begin
               in_q <= buf_out.in_num + 3'h1; // [RULE17]
            end
            astart_q <= acfg_q.enable;
         end
      end
   end

   // Bus sequencer: one owner at a time, fixed priority
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         own_q <= OWN_P0;
         bi_q <= 1'b0;
         mem_q <= '0;
      end else begin
         unique case (st_q)
            ST_IDLE: begin
               bi_q <= 1'b0;
               if (pend_q[0]) begin
                  own_q <= OWN_P0; // [RULE25]
                  st_q <= ST_REQ;
               end else if (pend_q[1]) begin
                  own_q <= OWN_P1; // [RULE25]
                  st_q <= ST_REQ;
               end else if (buf_vld && acfg_q.enable) begin
                  own_q <= OWN_ADC; // [RULE25]
                  st_q <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (bus_ack && own_is_p) begin
                  mem_q.rd <= 1'b1; // [RULE3]
                  mem_q.addr <= own_dir ? pr_addr : rf_addr; // [RULE2]
                  st_q <= ST_RD;
               end else if (bus_ack) begin
                  mem_q.wr <= 1'b1; // [RULE14]
                  mem_q.addr <= adc_dst;
                  mem_q.wdata <= buf_out.data[15:8];
                  st_q <= ST_WR;
               end
            end
            ST_RD: begin
               mem_q.rd <= 1'b0;
               st_q <= ST_LAT;
            end
            ST_LAT: begin
               mem_q.wr <= 1'b1;
               mem_q.addr <= own_dir ? rf_addr : pr_addr; // [RULE2]
               mem_q.wdata <= mem_rdata;
               st_q <= ST_WR;
            end
            ST_WR: begin
               mem_q.wr <= 1'b0;
               if (!bi_q && !own_is_p) begin
                  bi_q <= 1'b1;
                  mem_q.wr <= 1'b1; // [RULE14]
                  mem_q.addr <= {abase_q, 1'b0, buf_out.in_num, 1'b1};
                  mem_q.wdata <= buf_out.data[7:0];
               end else if (!bi_q && own_word) begin
                  bi_q <= 1'b1;
                  mem_q.rd <= 1'b1; // [RULE3]
                  mem_q.addr <= own_dir ? {PERIPH_PAGE,
                     cfg_q[own_q[0]].io | 8'h01} : cur_q[own_q[0]] + 12'h001;
                  st_q <= ST_RD;
               end else begin
                  st_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               bi_q <= 1'b0;
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
               mem_q <= '0;
            end
         endcase
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   AST_REQ_HOLD: assert property ( // [RULE26]
      (bus_req && !bus_ack && st_q == ST_REQ) |=> bus_req)
      else $error("bus request dropped before acknowledge");
   AST_REQ_DROP: assert property ( // [RULE26]
      $rose(st_q == ST_DONE) |-> !bus_req && $past(bus_req))
      else $error("bus request not dropped after transfer");
   AST_MEM_OWNED: assert property ( // [RULE3]
      (mem_bus.rd || mem_bus.wr) |-> bus_req)
      else $error("memory access without bus ownership");
   AST_PERIPH_PAGE: assert property ( // [RULE8]
      (mem_bus.rd && own_is_p && own_dir)
      |-> mem_bus.addr[11:8] == PERIPH_PAGE)
      else $error("peripheral read outside page F");
   AST_WRAP0: assert property ( // [RULE4]
      (step_pch[0] && hit_end[0] && !pch_load[0])
      |=> cur_q[0] == start_of(cfg_q[0]))
      else $error("current address not reloaded at end");
   AST_STEP0: assert property ( // [RULE7]
      (step_pch[0] && !hit_end[0] && !pch_load[0])
      |=> cur_q[0] == $past(cur_q[0]) +
      (cfg_q[0].ctl[CTL_WORD_BIT] ? ADDR_STEP_WORD : ADDR_STEP_BYTE))
      else $error("current address stepped wrongly");
   AST_IRQ0: assert property ( // [RULE5]
      (step_pch[0] && hit_end[0] && !pch_load[0])
      |=> pch_irq[0] == $past(cfg_q[0].ctl[CTL_IRQ_BIT]))
      else $error("end interrupt mismatch");
   AST_SINGLE0: assert property ( // [RULE6]
      (step_pch[0] && hit_end[0] && !pch_load[0]
      && !cfg_q[0].ctl[CTL_LOOP_BIT]) |=> !pch_enable[0])
      else $error("single pass left channel enabled");
   AST_IGNORE0: assert property (!en_q[0] |=> !pend_q[0]) // [RULE22]
      else $error("disabled channel kept a trigger");
   AST_PRIO: assert property ( // [RULE25]
      (st_q == ST_IDLE && pend_q[0])
      |=> st_q == ST_REQ && own_q == OWN_P0)
      else $error("peripheral channel 0 not served first");
   AST_ADC_WRAP: assert property ( // [RULE15]
      (step_adc && !adc_load &&
      buf_out.in_num >= acfg_q.in_count) |=> adc_input_sel == INPUT_FIRST
      && adc_irq == $past(acfg_q.irq_en))
      else $error("converter did not wrap to input 0");
   AST_ADC_NEXT: assert property ( // [RULE17]
      (step_adc && !adc_load &&
      buf_out.in_num < acfg_q.in_count) |=> adc_input_sel ==
      $past(buf_out.in_num) + 3'h1 && !adc_irq)
      else $error("converter did not advance input");
   AST_ADC_TWO: assert property ( // [RULE14]
      (st_q == ST_REQ && bus_ack &&
      own_q == OWN_ADC) |=> mem_bus.wr ##1 mem_bus.wr ##1 !mem_bus.wr)
      else $error("converter result not written as two bytes");
endmodule

// ==== testbench/tcdma_partner.sv ====
// Far-side model: bus-granting CPU, register file and converter
`timescale 1ns/1ps
module tcdma_partner import tcdma_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bus_req,
   output logic bus_ack,
   input wire tcdma_mem_s mem_bus,
   output logic [7:0] mem_rdata,
   input wire logic adc_start,
   input wire logic [2:0] adc_input_sel,
   input wire logic adc_ready,
   output logic adc_done,
   output logic [15:0] adc_data,
   input wire logic [1:0] ack_delay
);
   logic [7:0] mem [0:4095];
   int ack_n;
   int conv_n;
   // Grant after a bench-chosen delay, held while requested
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack <= 1'b0;
         ack_n <= 0;
      end else if (!bus_req) begin
         bus_ack <= 1'b0;
         ack_n <= 0;
      end else if (ack_n >= int'(ack_delay)) begin
         bus_ack <= 1'b1;
      end else begin
         ack_n <= ack_n + 1;
      end
   end
   // Read data stands one cycle, then scrambled so stale use shows
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata <= 8'h00;
      end else begin
         mem_rdata <= mem_bus.rd ? mem[mem_bus.addr] : ~mem_rdata;
         if (mem_bus.wr) begin
            mem[mem_bus.addr] <= mem_bus.wdata;
         end
      end
   end
   // Single-shot: one conversion per start pulse
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         adc_done <= 1'b0;
         adc_data <= 16'h0000;
         conv_n <= 0;
      end else if (adc_done && adc_ready) begin
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
      end else if (adc_start) begin
         conv_n <= 4;
      end else if (conv_n == 1) begin
         conv_n <= 0;
         adc_done <= 1'b1;
         adc_data <= {5'h1a, adc_input_sel, 5'h04, adc_input_sel};
      end else if (conv_n > 1) begin
         conv_n <= conv_n - 1;
      end else if (!adc_done) begin
         adc_data <= ~adc_data;
      end
   end
endmodule

// ==== testbench/three_channel_dma_controller_test.sv ====
// Self-checking bench for the three-channel transfer controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module three_channel_dma_controller_test import tcdma_pkg::*; ();
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   tcdma_pcfg_s [1:0] pch_cfg = '0;
   logic [1:0] pch_load = 2'h0;
   logic [1:0][7:0] pch_trig = '0;
   logic [6:0] adc_addr7 = 7'h30;
   tcdma_acfg_s adc_cfg = '0;
   logic adc_load = 1'b0;
   logic [1:0] ack_delay = 2'h0;
   logic [1:0] pch_enable, pch_irq;
   logic [1:0][11:0] pch_cur_addr;
   logic adc_done, adc_ready, adc_start, adc_irq, adc_enable;
   logic bus_req, bus_ack;
   logic [15:0] adc_data;
   logic [2:0] adc_input_sel;
   tcdma_mem_s mem_bus;
   logic [7:0] mem_rdata;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 61548;
   int cyc = 0;
   int k;
   int irq_n [3] = '{0, 0, 0};
   int m_cur [2], m_start [2], m_end [2];
   logic [7:0] m_ctl [2], m_io [2];
   logic [2:0] sel_q [$];

   tcdma_ctrl dut_u (.clk_sys, .rst_n, .pch_cfg, .pch_load, .pch_trig,
      .pch_enable, .pch_cur_addr, .pch_irq, .adc_addr7, .adc_cfg,
      .adc_load, .adc_done, .adc_data, .adc_ready, .adc_start,
      .adc_input_sel, .adc_irq, .adc_enable, .bus_req, .bus_ack,
      .mem_bus, .mem_rdata);
   tcdma_partner part_u (.clk_sys, .rst_n, .bus_req, .bus_ack, .mem_bus,
      .mem_rdata, .adc_start, .adc_input_sel, .adc_ready, .adc_done,
      .adc_data, .ack_delay);

   always #25 clk_sys = ~clk_sys;

   // Pulses are counted mid-cycle, away from the edge that launches them
   always @(negedge clk_sys) begin
      cyc++;
      if (pch_irq[0] === 1'b1) irq_n[0]++;
      if (pch_irq[1] === 1'b1) irq_n[1]++;
      if (adc_irq === 1'b1) irq_n[2]++;
      if (cyc > 30000) begin
         num_errors++;
         wrap_up();
      end
   end
   always @(negedge clk_sys) begin
      if (adc_start === 1'b1) sel_q.push_back(adc_input_sel);
   end

   task automatic wrap_up();
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic load(input int ch, input logic [7:0] ctl, io, hi, slo,
         elo);
      @(negedge clk_sys);
      pch_cfg[ch] = {ctl, io, hi, slo, elo};
      pch_load[ch] = 1'b1;
      m_ctl[ch] = ctl;
      m_io[ch] = io;
      m_start[ch] = {hi[3:0], slo};
      m_end[ch] = {hi[7:4], elo};
      m_cur[ch] = m_start[ch];
      @(negedge clk_sys);
      pch_load[ch] = 1'b0;
      `CHK(pch_enable[ch], ctl[7])
      `CHK(pch_cur_addr[ch], 12'(m_start[ch]))
   endtask

   function automatic void step(input int ch);
      if (m_cur[ch] == m_end[ch]) begin
         m_cur[ch] = m_start[ch];
         if (!m_ctl[ch][6]) m_ctl[ch][7] = 1'b0;
      end else begin
         m_cur[ch] += m_ctl[ch][3] ? 2 : 1;
      end
   endfunction

   task automatic pulse(input logic [1:0] m, input int code);
      @(negedge clk_sys);
      ack_delay = 2'($random(seed));
      for (int i = 0; i < 2; i++) pch_trig[i][code] = m[i];
      @(negedge clk_sys);
      pch_trig = '0;
   endtask

   // Bounded: a refused trigger simply never raises the request
   task automatic wait_fall();
      int n;
      n = 0;
      while (bus_req !== 1'b1 && n < 12) begin
         @(negedge clk_sys);
         n++;
      end
      while (bus_req === 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic xfer(input int ch);
      logic [11:0] pa, src, dst;
      logic [7:0] b0, b1, d_old;
      logic live, wrap;
      int irq0;
      pa = {4'hf, m_io[ch]};
      src = m_ctl[ch][5] ? pa : 12'(m_cur[ch]);
      dst = m_ctl[ch][5] ? 12'(m_cur[ch]) : pa;
      b0 = part_u.mem[src];
      b1 = part_u.mem[src + 12'h1];
      d_old = part_u.mem[dst];
      live = m_ctl[ch][7] && m_ctl[ch][2:0] != 3'h3
         && m_ctl[ch][2:0] != 3'h7;
      wrap = live && m_cur[ch] == m_end[ch];
      irq0 = irq_n[ch];
      pulse(2'(1 << ch), int'(m_ctl[ch][2:0]));
      wait_fall();
      `CHK(part_u.mem[dst], live ? b0 : d_old)
      if (live && m_ctl[ch][3]) `CHK(part_u.mem[dst + 12'h1], b1)
      `CHK(part_u.mem[src], b0)
      if (live) step(ch);
      `CHK(pch_cur_addr[ch], 12'(m_cur[ch]))
      `CHK(pch_enable[ch], m_ctl[ch][7])
      `CHK(irq_n[ch], irq0 + int'(wrap && m_ctl[ch][4]))
   endtask

   initial begin
      for (int i = 0; i < 4096; i++) part_u.mem[i] = 8'($random(seed));
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      `CHK(pch_enable, 2'h0)
      `CHK(adc_ready, 1'b1)
      `CHK(bus_req, 1'b0)
      // Every trigger code once; 011 and 111 must stay silent
      for (int c = 0; c < 8; c++) begin
         load(1, 8'hc0 | 8'(c), 8'h44, 8'h00, 8'h40, 8'h47);
         xfer(1);
      end
      // Single pass across a low-byte rollover; fourth trigger ignored
      load(0, 8'h90, 8'h10, 8'h21, 8'hfe, 8'h00);
      repeat (4) xfer(0);
      // Word, peripheral to register file, looping with interrupt
      load(1, 8'hf9, 8'h20, 8'h00, 8'h30, 8'h32);
      repeat (3) xfer(1);
      // Both channels triggered together: channel 0 served first
      load(0, 8'hc0, 8'h12, 8'h00, 8'h50, 8'h5f);
      load(1, 8'hc0, 8'h14, 8'h00, 8'h60, 8'h6f);
      pulse(2'h3, 0);
      wait_fall();
      `CHK(pch_cur_addr, {12'h060, 12'h051})
      wait_fall();
      `CHK(pch_cur_addr[1], 12'h061)
      // Converter scan of inputs 0 to 2 with interrupt on wrap
      @(negedge clk_sys);
      adc_cfg = '{irq_en: 1'b1, in_count: 3'h2, enable: 1'b1};
      adc_load = 1'b1;
      @(negedge clk_sys);
      adc_load = 1'b0;
      `CHK(adc_enable, 1'b1)
      k = 0;
      while (irq_n[2] == 0 && k < 400) begin
         @(negedge clk_sys);
         k++;
      end
      `CHK(adc_input_sel, 3'h0)
      @(negedge clk_sys);
      adc_cfg = '{irq_en: 1'b1, in_count: 3'h2, enable: 1'b0};
      adc_load = 1'b1;
      @(negedge clk_sys);
      adc_load = 1'b0;
      for (int i = 0; i < 3; i++) begin
         `CHK(part_u.mem[{adc_addr7, 1'b0, 3'(i), 1'b0}], 8'hd0 | 8'(i))
         `CHK(part_u.mem[{adc_addr7, 1'b0, 3'(i), 1'b1}], 8'h20 | 8'(i))
         `CHK(sel_q[i], 3'(i))
      end
      `CHK(sel_q[3], 3'h0)
      `CHK(irq_n[2], 1)
      wrap_up();
   end
endmodule
